// File: bmc_regs.svh
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH

// Register byte offsets, decoded on haddr[7:2]
`define BMC_OFF_CONFIG     8'h00
`define BMC_OFF_RAM_SIZE   8'h10
`define BMC_OFF_USER_BASE  8'h20
`define BMC_OFF_FLASH_SIZE 8'h30
`define BMC_OFF_IRQ_STAT   8'h40
`define BMC_OFF_IRQ_MASK   8'h44
`define BMC_OFF_ERR_ADDR   8'h48
`define BMC_OFF_ERR_SRC    8'h4c

// Configuration register fields
`define BMC_BIT_ERR_FIRST  16
`define BMC_BIT_WAIT_SEL   6
`define BMC_ARB_MSB        2
`define BMC_ARB_LSB        0
`define BMC_CFG_RESET      32'h001f_0041
`define BMC_CFG_WMASK      32'h001f_0047

// User program base address: bits 19..11 writable
`define BMC_UBASE_WMASK    32'h000f_f800
`define BMC_UBASE_RESET    32'h0000_0000

// Interrupt block
`define BMC_NUM_SRC        5
`define BMC_IRQ_RESET      5'h00

// Arbitration codes
`define BMC_ARB_MODE0      3'h0
`define BMC_ARB_MODE1      3'h1
`define BMC_ARB_MODE2      3'h2

`endif

// File: bmc_pkg.sv
package bmc_pkg;

    // Initiator index; bit position in the config register is 16 + index
    typedef enum logic [2:0] {
        BMC_SRC_CPU_INSTR = 3'h0,
        BMC_SRC_CPU_DATA  = 3'h1,
        BMC_SRC_DMA       = 3'h2,
        BMC_SRC_DEBUG     = 3'h3,
        BMC_SRC_SHARED    = 3'h4
    } bmc_src_t;

    typedef struct packed {
        logic        err;
        logic [31:0] addr;
    } bmc_gate_state_t;

    typedef struct packed {
        logic setup;
        logic go;
    } bmc_wait_state_t;

    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] userBase;
        logic [4:0]  irqStat;
        logic [4:0]  irqMask;
        logic [31:0] errAddr;
        logic [4:0]  errSrc;
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdata;
        logic        ready;
        logic        resp;
        logic        irq;
    } bmc_top_state_t;

endpackage : bmc_pkg

// File: bmc_err_gate.sv
`timescale 1ns/1ps

module bmc_err_gate #(
    parameter bit DEBUG_SUPPRESS = 1'b0
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Control
    input  wire logic        enable,
    input  wire logic        debugMode,
    // Initiator access
    input  wire logic        access,
    input  wire logic        unmapped,
    input  wire logic [31:0] addr,
    // Result
    output logic             busError,
    output logic [31:0]      errAddr
);

    bmc_pkg::bmc_gate_state_t s_q;
    bmc_pkg::bmc_gate_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.err  = access && unmapped && enable && !(DEBUG_SUPPRESS && debugMode);
        if (s_d.err) begin
            s_d.addr = addr;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busError = s_q.err;
    assign errAddr  = s_q.addr;

endmodule : bmc_err_gate

// File: bmc_ram_wait.sv
`timescale 1ns/1ps

module bmc_ram_wait (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Control
    input  wire logic waitSel,
    // CPU data RAM access
    input  wire logic ramReq,
    output logic      ramGo
);

    bmc_pkg::bmc_wait_state_t s_q;
    bmc_pkg::bmc_wait_state_t s_d;

    // Request is held until ramGo; one setup cycle is inserted when selected
    always_comb begin
        s_d = '0;
        if (ramReq && !s_q.go) begin
            if (waitSel && !s_q.setup) begin
                s_d.setup = 1'b1;
            end else begin
                s_d.go = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ramGo = s_q.go;

endmodule : bmc_ram_wait

// File: bmc_top.sv
`timescale 1ns/1ps
`include "bmc_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: Shared-bus unmapped access raises bus error only when its enable is set.
// R2: Debug-unit unmapped access raises bus error only when its enable is set.
// R3: DMA unmapped access raises bus error only when its enable is set.
// R4: CPU data unmapped access error when enabled, never in debug mode.
// R5: CPU fetch unmapped access error when enabled, never in debug mode.
// R6: Wait bit set gives CPU data RAM accesses one setup wait state.
// R7: Arbitration code 000/001/010 selects mode 0/1/2; mode 1 after reset.
// R8: Software never writes arbitration codes 011 to 111.
// R9: Config unimplemented bits read zero and ignore writes.
// R10: Data RAM size register is a read-only byte-size constant.
// R11: User base address writable in bits 19..11; bits 31..20 read zero.
// R12: User base bits 10..0 read-only zero, giving 2 KB steps.
// R13: User base address clears to zero on reset.
// R14: Software keeps user base no greater than program flash size.
////////////////////////////////////////////////////////////////////////////////

module bmc_top #(
    parameter logic [31:0] RAM_SIZE_BYTES   = 32'h0000_4000,
    parameter logic [31:0] FLASH_SIZE_BYTES = 32'h0001_0000
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // CPU state
    input  wire logic        debugMode,
    // CPU instruction initiator
    input  wire logic        cpuInstrAccess,
    input  wire logic        cpuInstrUnmapped,
    input  wire logic [31:0] cpuInstrAddr,
    output logic             cpuInstrBusError,
    // CPU data initiator
    input  wire logic        cpuDataAccess,
    input  wire logic        cpuDataUnmapped,
    input  wire logic [31:0] cpuDataAddr,
    output logic             cpuDataBusError,
    // DMA initiator
    input  wire logic        dmaAccess,
    input  wire logic        dmaUnmapped,
    input  wire logic [31:0] dmaAddr,
    output logic             dmaBusError,
    // Debug unit initiator
    input  wire logic        debugAccess,
    input  wire logic        debugUnmapped,
    input  wire logic [31:0] debugAddr,
    output logic             debugBusError,
    // Shared peripheral bus initiator
    input  wire logic        sharedAccess,
    input  wire logic        sharedUnmapped,
    input  wire logic [31:0] sharedAddr,
    output logic             sharedBusError,
    // CPU access to data RAM
    input  wire logic        cpuRamReq,
    output logic             cpuRamGo,
    // Configuration to the matrix
    output logic [2:0]       arbMode,
    output logic [31:0]      userBaseAddr,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Initiator gathering

    localparam int NSRC = `BMC_NUM_SRC;

    logic [NSRC-1:0] accessVec;
    logic [NSRC-1:0] unmappedVec;
    logic [31:0]     addrArr    [NSRC];
    logic [NSRC-1:0] errVec;
    logic [31:0]     errAddrArr [NSRC];

    assign accessVec   = {sharedAccess, debugAccess, dmaAccess,
                          cpuDataAccess, cpuInstrAccess};
    assign unmappedVec = {sharedUnmapped, debugUnmapped, dmaUnmapped,
                          cpuDataUnmapped, cpuInstrUnmapped};

    // CPU instruction and data checking stops in debug mode
    localparam logic [NSRC-1:0] SUPPRESS_VEC = 5'h03;

    assign addrArr[bmc_pkg::BMC_SRC_CPU_INSTR] = cpuInstrAddr;
    assign addrArr[bmc_pkg::BMC_SRC_CPU_DATA]  = cpuDataAddr;
    assign addrArr[bmc_pkg::BMC_SRC_DMA]       = dmaAddr;
    assign addrArr[bmc_pkg::BMC_SRC_DEBUG]     = debugAddr;
    assign addrArr[bmc_pkg::BMC_SRC_SHARED]    = sharedAddr;

    bmc_pkg::bmc_top_state_t s_q;
    bmc_pkg::bmc_top_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // Per-initiator error gates

    for (genvar i = 0; i < NSRC; i++) begin : g_gate
        bmc_err_gate #(
            .DEBUG_SUPPRESS (SUPPRESS_VEC[i])
        ) u_gate (
            .mclk      (mclk),
            .srst      (srst),
            .enable    (s_q.cfg[`BMC_BIT_ERR_FIRST + i]), // [R1] [R2] [R3] [R4] [R5]
            .debugMode (debugMode),                       // [R4] [R5]
            .access    (accessVec[i]),
            .unmapped  (unmappedVec[i]),
            .addr      (addrArr[i]),
            .busError  (errVec[i]),
            .errAddr   (errAddrArr[i])
        );
    end

    assign cpuInstrBusError = errVec[bmc_pkg::BMC_SRC_CPU_INSTR];
    assign cpuDataBusError  = errVec[bmc_pkg::BMC_SRC_CPU_DATA];
    assign dmaBusError      = errVec[bmc_pkg::BMC_SRC_DMA];
    assign debugBusError    = errVec[bmc_pkg::BMC_SRC_DEBUG];
    assign sharedBusError   = errVec[bmc_pkg::BMC_SRC_SHARED];

    ////////////////////////////////////////////////////////////////////////////
    // Data RAM wait state

    bmc_ram_wait u_wait (
        .mclk    (mclk),
        .srst    (srst),
        .waitSel (s_q.cfg[`BMC_BIT_WAIT_SEL]), // [R6]
        .ramReq  (cpuRamReq),
        .ramGo   (cpuRamGo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    function automatic logic [31:0] readMux(
        input logic [7:0]               off,
        input bmc_pkg::bmc_top_state_t  st
    );
        logic [31:0] val;
        val = 32'h0000_0000;
        case (off)
            `BMC_OFF_CONFIG: begin
                val = st.cfg & `BMC_CFG_WMASK; // [R9]
            end
            `BMC_OFF_RAM_SIZE: begin
                val = RAM_SIZE_BYTES; // [R10]
            end
            `BMC_OFF_USER_BASE: begin
                val = st.userBase & `BMC_UBASE_WMASK; // [R11] [R12]
            end
            `BMC_OFF_FLASH_SIZE: begin
                val = FLASH_SIZE_BYTES; // [R14]
            end
            `BMC_OFF_IRQ_STAT: begin
                val = {27'h0000000, st.irqStat};
            end
            `BMC_OFF_IRQ_MASK: begin
                val = {27'h0000000, st.irqMask};
            end
            `BMC_OFF_ERR_ADDR: begin
                val = st.errAddr;
            end
            `BMC_OFF_ERR_SRC: begin
                val = {27'h0000000, st.errSrc};
            end
            default: begin
                val = 32'h0000_0000;
            end
        endcase
        return val;
    endfunction : readMux

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic            busTake;
    logic [NSRC-1:0] clrMask;

    assign busTake = hsel && htrans[1] && hready;

    always_comb begin
        s_d     = s_q;
        clrMask = '0;

        // Data phase of a write taken in the previous cycle
        if (s_q.wrPend) begin
            case (s_q.wrAddr)
                `BMC_OFF_CONFIG: begin
                    s_d.cfg = hwdata & `BMC_CFG_WMASK; // [R7] [R9]
                end
                `BMC_OFF_USER_BASE: begin
                    s_d.userBase = hwdata & `BMC_UBASE_WMASK; // [R11] [R12]
                end
                `BMC_OFF_IRQ_STAT: begin
                    clrMask = hwdata[NSRC-1:0];
                end
                `BMC_OFF_IRQ_MASK: begin
                    s_d.irqMask = hwdata[NSRC-1:0];
                end
                default: begin
                    s_d.cfg = s_q.cfg;
                end
            endcase
        end

        // Sticky error status; a new event beats a clear in the same cycle
        s_d.irqStat = (s_q.irqStat & ~clrMask) | errVec;

        // Capture the address of the lowest-numbered erring initiator
        if (|errVec) begin
            s_d.errSrc = errVec;
            for (int k = NSRC - 1; k >= 0; k--) begin
                if (errVec[k]) begin
                    s_d.errAddr = errAddrArr[k];
                end
            end
        end

        // Address phase; reads see a write completing in the same cycle
        s_d.wrPend = busTake && hwrite;
        s_d.wrAddr = {haddr[7:2], 2'b00};
        if (busTake && !hwrite) begin
            s_d.rdata = readMux({haddr[7:2], 2'b00}, s_d);
        end

        s_d.ready = 1'b1;
        s_d.resp  = 1'b0;
        s_d.irq   = |(s_d.irqStat & s_d.irqMask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q          <= '0;
            s_q.cfg      <= `BMC_CFG_RESET;   // [R7]
            s_q.userBase <= `BMC_UBASE_RESET; // [R13]
            s_q.irqStat  <= `BMC_IRQ_RESET;
            s_q.irqMask  <= `BMC_IRQ_RESET;
            s_q.ready    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata       = s_q.rdata;
    assign hreadyout    = s_q.ready;
    assign hresp        = s_q.resp;
    assign arbMode      = s_q.cfg[`BMC_ARB_MSB:`BMC_ARB_LSB]; // [R7]
    assign userBaseAddr = s_q.userBase;
    assign irq          = s_q.irq;

endmodule : bmc_top

// File: bmc_top_sva.sv
`timescale 1ns/1ps

module bmc_top_sva (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // Initiators
    input wire logic        debugMode,
    input wire logic        cpuInstrAccess,
    input wire logic        cpuInstrUnmapped,
    input wire logic        cpuInstrBusError,
    input wire logic        cpuDataAccess,
    input wire logic        cpuDataUnmapped,
    input wire logic        cpuDataBusError,
    input wire logic        dmaAccess,
    input wire logic        dmaUnmapped,
    input wire logic        dmaBusError,
    input wire logic        debugAccess,
    input wire logic        debugUnmapped,
    input wire logic        debugBusError,
    input wire logic        sharedAccess,
    input wire logic        sharedUnmapped,
    input wire logic        sharedBusError,
    // Matrix side
    input wire logic        cpuRamReq,
    input wire logic        cpuRamGo,
    input wire logic [2:0]  arbMode,
    input wire logic [31:0] userBaseAddr,
    // Register bus response
    input wire logic        hreadyout,
    input wire logic        hresp
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_shared_cause: assert property (
        sharedBusError |-> $past(sharedAccess & sharedUnmapped))
        else $error("shared bus error without cause");
    chk_debug_cause: assert property (
        debugBusError |-> $past(debugAccess & debugUnmapped))
        else $error("debug bus error without cause");
    chk_dma_cause: assert property (
        dmaBusError |-> $past(dmaAccess & dmaUnmapped))
        else $error("dma bus error without cause");
    chk_data_cause: assert property (
        cpuDataBusError |-> $past(cpuDataAccess & cpuDataUnmapped & !debugMode))
        else $error("data bus error without cause");
    chk_instr_cause: assert property (
        cpuInstrBusError |-> $past(cpuInstrAccess & cpuInstrUnmapped & !debugMode))
        else $error("fetch bus error without cause");
    chk_ram_cause: assert property (
        cpuRamGo |-> $past(cpuRamReq))
        else $error("ram go without request");
    chk_ram_bound: assert property (
        $rose(cpuRamReq) |-> ##[1:2] cpuRamGo)
        else $error("ram go late");
    chk_reset_values: assert property (
        $fell(srst) |-> arbMode == 3'h1 && userBaseAddr == 32'h0)
        else $error("wrong value after reset");
    chk_base_zero: assert property (
        userBaseAddr[31:20] == 12'h0 && userBaseAddr[10:0] == 11'h0)
        else $error("user base fixed bits not zero");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or response not okay");

    cover property (dmaBusError);
    cover property ($rose(cpuRamReq) ##2 cpuRamGo);
    cover property (arbMode == 3'h2);
endmodule : bmc_top_sva

bind bmc_top bmc_top_sva bmc_top_sva_inst (.*);

// File: bmc_initiators.sv
`timescale 1ns/1ps

module bmc_initiators (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Bench commands
    input  wire logic [4:0]  fire,
    input  wire logic [4:0]  bad,
    input  wire logic        ramStart,
    // Initiator side
    output logic      [4:0]  acc,
    output logic      [4:0]  unm,
    output logic      [31:0] addr,
    // Data RAM requester
    input  wire logic        ramGo,
    output logic             ramReq,
    output logic      [1:0]  ramLat
);
    always_ff @(posedge mclk) begin
        acc <= srst ? 5'h0 : fire;
        unm <= srst ? 5'h0 : fire & bad;
        addr <= srst ? 32'h0 : {addr[30:0], ~addr[31]};
    end
    // Request held until go, then dropped; ramLat counts cycles waited
    always_ff @(posedge mclk) begin
        if (srst) begin
            ramReq <= 1'b0;
            ramLat <= 2'h0;
        end else if (ramReq && ramGo) begin
            ramReq <= 1'b0;
        end else if (ramReq) begin
            ramLat <= ramLat + 2'h1;
        end else if (ramStart) begin
            ramReq <= 1'b1;
            ramLat <= 2'h0;
        end
    end
endmodule : bmc_initiators

// File: bmc_top_tb.sv
`timescale 1ns/1ps

module bmc_top_tb;
    logic        mclk, srst, hwrite, debugMode, ramStart, hreadyout, cpuRamReq, cpuRamGo, irq;
    logic        hresp;
    logic [1:0]  htrans, ramLat;
    logic [2:0]  arbMode;
    logic [4:0]  fire, bad, msk, acc, unm, busErr;
    logic [31:0] haddr, hwdata, hrdata, userBaseAddr, addr, rd, seed;
    int          n_fail, checks_done, cycles;

    bmc_top bmc_top_inst (
        .mclk(mclk), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .debugMode(debugMode),
        .cpuInstrAccess(acc[0]), .cpuInstrUnmapped(unm[0]), .cpuInstrAddr(addr),
        .cpuInstrBusError(busErr[0]), .cpuDataAccess(acc[1]), .cpuDataUnmapped(unm[1]),
        .cpuDataAddr(addr), .cpuDataBusError(busErr[1]), .dmaAccess(acc[2]),
        .dmaUnmapped(unm[2]), .dmaAddr(addr), .dmaBusError(busErr[2]),
        .debugAccess(acc[3]), .debugUnmapped(unm[3]), .debugAddr(addr),
        .debugBusError(busErr[3]), .sharedAccess(acc[4]), .sharedUnmapped(unm[4]),
        .sharedAddr(addr), .sharedBusError(busErr[4]), .cpuRamReq(cpuRamReq),
        .cpuRamGo(cpuRamGo), .arbMode(arbMode), .userBaseAddr(userBaseAddr), .irq(irq)
    );
    bmc_initiators bmc_initiators_inst (
        .mclk(mclk), .srst(srst), .fire(fire), .bad(bad), .ramStart(ramStart),
        .acc(acc), .unm(unm), .addr(addr), .ramGo(cpuRamGo), .ramReq(cpuRamReq),
        .ramLat(ramLat)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic expErr(input int i, input logic en);
        return en && bad[i] && !(debugMode && i < 2);
    endfunction : expErr
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rchk(input logic [7:0] a, input logic [31:0] want);
        ahb(1'b0, a, 32'h0);
        chk(rd, want);
        chk(32'(hresp), 32'h0);
    endtask : rchk
    task automatic pulse(input int i, input logic en);
        logic hit;
        fire <= 5'(1 << i);
        @(posedge mclk);
        hit = expErr(i, en);
        fire <= 5'h0;
        @(posedge mclk);
        @(negedge mclk);
        chk(32'(busErr), hit ? 32'(1 << i) : 32'h0);
        @(posedge mclk);
        @(negedge mclk);
        chk(32'(irq), 32'(hit & msk[i]));
        @(posedge mclk);
        rchk(8'h40, hit ? 32'(1 << i) : 32'h0);
        if (hit) rchk(8'h4c, 32'(1 << i));
        ahb(1'b1, 8'h40, 32'h1f);
        @(posedge mclk);
        @(negedge mclk);
        chk(32'(irq), 32'h0);
        @(posedge mclk);
    endtask : pulse

    initial begin
        srst = 1'b1;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        debugMode = 1'b0;
        ramStart = 1'b0;
        fire = 5'h0;
        bad = 5'h1f;
        msk = 5'h1f;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rchk(8'h00, 32'h001f_0041);
        rchk(8'h10, 32'h0000_4000);
        rchk(8'h20, 32'h0);
        ahb(1'b1, 8'h00, 32'hffff_fffa);
        rchk(8'h00, 32'h001f_0042);
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        rchk(8'h10, 32'h0000_4000);
        rchk(8'h3c, 32'h0);
        rchk(8'h30, 32'h0001_0000);
        for (int c = 0; c < 3; c++) begin
            ahb(1'b1, 8'h00, 32'(c));
            @(negedge mclk);
            chk(32'(arbMode), 32'(c));
            @(posedge mclk);
        end
        ahb(1'b1, 8'h20, 32'h0001_0000);
        rchk(8'h20, 32'h0001_0000);
        seed = 32'hfbd2;
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            ahb(1'b1, 8'h20, seed & 32'hfff0_ffff);
            rchk(8'h20, seed & 32'h0000_f800);
            chk(userBaseAddr, seed & 32'h0000_f800);
        end
        // Reset in mid-run must restore the config and user base reset values
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rchk(8'h00, 32'h001f_0041);
        rchk(8'h20, 32'h0);
        for (int w = 0; w < 2; w++) begin
            ahb(1'b1, 8'h00, (32'(w) << 6) | 32'h1);
            ramStart <= 1'b1;
            @(posedge mclk);
            ramStart <= 1'b0;
            repeat (2) @(posedge mclk);
            while (cpuRamReq) @(posedge mclk);
            chk(32'(ramLat), 32'(w + 1));
        end
        ahb(1'b1, 8'h44, 32'h1f);
        rchk(8'h44, 32'h0000_001f);
        for (int e = 0; e < 2; e++) begin
            ahb(1'b1, 8'h00, e ? 32'h001f_0001 : 32'h1);
            for (int d = 0; d < 2; d++) begin
                debugMode <= d[0];
                for (int i = 0; i < 5; i++) pulse(i, e[0]);
            end
        end
        debugMode <= 1'b0;
        bad <= seed[4:0] & 5'h1b;
        pulse(2, 1'b1);
        msk = 5'h0;
        bad <= 5'h1f;
        ahb(1'b1, 8'h44, 32'h0);
        pulse(2, 1'b1);
        end_sim();
    end
endmodule : bmc_top_tb
